// ===== rtl/ebt_cfg.svh
// register map, field positions, reset values and counts of the 8-bit timer
`ifndef EBT_CFG_SVH
`define EBT_CFG_SVH

`define EBT_ADDR_CTRL    3'h0
`define EBT_ADDR_CMP     3'h1
`define EBT_ADDR_DUTY    3'h2
`define EBT_ADDR_CFG     3'h3
`define EBT_ADDR_CNT     3'h4

`define EBT_CTRL_FF_BIT  7
`define EBT_CTRL_SRC_HI  6
`define EBT_CTRL_SRC_LO  4
`define EBT_CTRL_RUN_BIT 3
`define EBT_CTRL_MODE_HI 2
`define EBT_CTRL_MODE_LO 0

`define EBT_CFG_TAP_BIT  0
`define EBT_CFG_SLOW_BIT 1

`define EBT_CTRL_RST     8'h00
`define EBT_CMP_RST      8'h00
`define EBT_DUTY_RST     8'h00
`define EBT_CFG_RST      2'h0
`define EBT_CNT_TOP      8'hff

`define EBT_DIV_W        11
`define EBT_CLOCK_MHZ    100

`endif

// ===== rtl/ebt_pkg.sv
// types shared by the 8-bit timer
package ebt_pkg;

   typedef enum logic [2:0]
   {
      EBT_MODE_TIMER = 3'h0,
      EBT_MODE_PDO   = 3'h1,
      EBT_MODE_PWM   = 3'h2,
      EBT_MODE_RSVD  = 3'h3
   } ebt_mode_e;

   typedef enum logic [2:0]
   {
      EBT_SRC_SLOW8 = 3'h0,
      EBT_SRC_D7    = 3'h1,
      EBT_SRC_D5    = 3'h2,
      EBT_SRC_D3    = 3'h3,
      EBT_SRC_FS    = 3'h4,
      EBT_SRC_D1    = 3'h5,
      EBT_SRC_FC    = 3'h6,
      EBT_SRC_PIN   = 3'h7
   } ebt_src_e;

endpackage

// ===== rtl/ebt_timer.sv
// one 8-bit timer/counter channel: timer, event, divider and pwm modes
//
// How it works
// - timer mode: count, match irq, clear, continue
// - timer compare value acts immediately, unbuffered
// - event mode counts pin falling edges, match clears
// - event compare value acts immediately, unbuffered
// - divider mode toggles flip-flop on each match
// - divider pin is inverse flip-flop, resets zero
// - divider compare value acts immediately, unbuffered
// - stop holds pin; flip-flop rewritten afterwards
// - bit 3 runs timer, bit 7 flip-flop
// - pwm toggles at duty and at overflow
// - pwm pin inverse flip-flop, programmable, resets zero
// - duty buffered, moves at irq or immediately
// - duty read shows old value until irq
// - fast taps 2^11/fs8, 2^7, 2^5, 2^3
//
// The placing of the registers and the plain strobed port were left to the implementer.
`timescale 1ns/10ps
`include "ebt_cfg.svh"

module ebt_timer
(
   input  wire logic       i_clock,
   input  wire logic       i_srst,
   input  wire logic [2:0] i_addr,
   input  wire logic [7:0] i_wdata,
   input  wire logic       i_wr,
   input  wire logic       i_rd,
   input  wire logic       i_low_freq_clock,
   input  wire logic       i_event_in_pin,
   output logic      [7:0] o_rdata,
   output logic            o_match_irq,
   output logic            o_divider_out_pin,
   output logic            o_pwm_out_pin
);

   logic [7:0]              timer_ctrl_reg;
   logic [7:0]              compare_reg;
   logic [7:0]              duty_buf_reg;
   logic [7:0]              pwm_duty_reg;
   logic [1:0]              cfg_reg;
   logic [7:0]              cnt_reg;
   logic [7:0]              cnt_next;
   logic [7:0]              cnt_inc;
   logic [7:0]              rdata_reg;
   logic [`EBT_DIV_W-1:0]   div_reg;
   logic [`EBT_DIV_W-1:0]   tap_vec;
   logic [2:0]              fs_div_reg;
   logic [1:0]              fs_sync_reg;
   logic                    fs_last_reg;
   logic [1:0]              ev_sync_reg;
   logic                    ev_last_reg;
   logic                    ff_reg;
   logic                    ff_next;
   logic                    irq_reg;
   logic                    irq_next;
   logic                    load_duty;
   logic                    pdo_pin_reg;
   logic                    pwm_pin_reg;
   logic                    run;
   logic                    tick;
   logic                    fs_rise;
   logic                    fs8_tick;
   logic                    ev_fall;
   logic                    ctrl_wr;
   logic                    cmp_wr;
   logic                    duty_wr;
   logic                    cfg_wr;
   ebt_pkg::ebt_mode_e      mode;
   ebt_pkg::ebt_src_e       src;

   // picks the source tick; slow mode has no high clock taps
   function automatic logic src_tick
   (
      input ebt_pkg::ebt_src_e     s,
      input logic [`EBT_DIV_W-1:0] t,
      input logic [1:0]            c,
      input logic                  f8,
      input logic                  f1,
      input logic                  ev
   );
      logic r;
      logic slow;
      r = 1'b0;
      slow = c[`EBT_CFG_SLOW_BIT];
      case (s)
         ebt_pkg::EBT_SRC_SLOW8:
            r = (c[`EBT_CFG_TAP_BIT] || slow) ? f8 : t[10];
         ebt_pkg::EBT_SRC_D7:
            r = t[6] && !slow;
         ebt_pkg::EBT_SRC_D5:
            r = t[4] && !slow;
         ebt_pkg::EBT_SRC_D3:
            r = t[2] && !slow;
         ebt_pkg::EBT_SRC_FS:
            r = f1;
         ebt_pkg::EBT_SRC_D1:
            r = t[0] && !slow;
         ebt_pkg::EBT_SRC_FC:
            r = !slow;
         ebt_pkg::EBT_SRC_PIN:
            r = ev;
         default:
            r = 1'b0;
      endcase
      return r;
   endfunction

   assign ctrl_wr = i_wr && (i_addr == `EBT_ADDR_CTRL);
   assign cmp_wr  = i_wr && (i_addr == `EBT_ADDR_CMP);
   assign duty_wr = i_wr && (i_addr == `EBT_ADDR_DUTY);
   assign cfg_wr  = i_wr && (i_addr == `EBT_ADDR_CFG);

   assign run  = timer_ctrl_reg[`EBT_CTRL_RUN_BIT];
   assign mode = ebt_pkg::ebt_mode_e'(
                 timer_ctrl_reg[`EBT_CTRL_MODE_HI:`EBT_CTRL_MODE_LO]);
   assign src  = ebt_pkg::ebt_src_e'(
                 timer_ctrl_reg[`EBT_CTRL_SRC_HI:`EBT_CTRL_SRC_LO]);

   // free prescaler; tap g pulses once every 2^(g+1) clocks
   always_ff @(posedge i_clock)
   begin
      if (i_srst)
         div_reg <= '0;
      else
         div_reg <= div_reg + `EBT_DIV_W'h001;
   end

   genvar g;
   generate
      for (g = 0; g < `EBT_DIV_W; g = g + 1)
      begin : g_tap
         assign tap_vec[g] = &div_reg[g:0];
      end
   endgenerate

   // low clock and event pin are asynchronous: two flops first
   always_ff @(posedge i_clock)
   begin
      if (i_srst)
      begin
         fs_sync_reg <= 2'h0;
         fs_last_reg <= 1'b0;
         ev_sync_reg <= 2'h3;
         ev_last_reg <= 1'b1;
      end
      else
      begin
         fs_sync_reg <= {fs_sync_reg[0], i_low_freq_clock};
         fs_last_reg <= fs_sync_reg[1];
         ev_sync_reg <= {ev_sync_reg[0], i_event_in_pin};
         ev_last_reg <= ev_sync_reg[1];
      end
   end

   assign fs_rise  = fs_sync_reg[1] && !fs_last_reg;
   assign ev_fall  = ev_last_reg && !ev_sync_reg[1];
   assign fs8_tick = fs_rise && (&fs_div_reg);

   always_ff @(posedge i_clock)
   begin
      if (i_srst)
         fs_div_reg <= 3'h0;
      else if (fs_rise)
         fs_div_reg <= fs_div_reg + 3'h1;
   end

   // short event pulses are missed; the source must hold levels
   assign tick = run && src_tick(src, tap_vec, cfg_reg,
                                 fs8_tick, fs_rise, ev_fall);

   assign cnt_inc = cnt_reg + 8'h01;

   always_comb
   begin
      cnt_next  = cnt_reg;
      ff_next   = ff_reg;
      irq_next  = 1'b0;
      load_duty = 1'b0;
      if (ctrl_wr && !run)
      begin
         // only a stopped timer takes the flip-flop value
         cnt_next = 8'h00;
         ff_next  = i_wdata[`EBT_CTRL_FF_BIT];
      end
      else if (tick)
      begin
         case (mode)
            ebt_pkg::EBT_MODE_TIMER,
            ebt_pkg::EBT_MODE_PDO:
            begin
               if (cnt_inc == compare_reg)
               begin
                  cnt_next = 8'h00;
                  irq_next = 1'b1;
                  if (mode == ebt_pkg::EBT_MODE_PDO)
                     ff_next = !ff_reg;
               end
               else
                  cnt_next = cnt_inc;
            end
            ebt_pkg::EBT_MODE_PWM:
            begin
               if (cnt_reg == `EBT_CNT_TOP)
               begin
                  cnt_next  = 8'h00;
                  ff_next   = !ff_reg;
                  irq_next  = 1'b1;
                  load_duty = 1'b1;
               end
               else
               begin
                  cnt_next = cnt_inc;
                  if (cnt_inc == pwm_duty_reg)
                     ff_next = !ff_reg;
               end
            end
            default:
               cnt_next = cnt_reg;
         endcase
      end
   end

   always_ff @(posedge i_clock)
   begin
      if (i_srst)
      begin
         cnt_reg     <= 8'h00;
         ff_reg      <= 1'b0;
         irq_reg     <= 1'b0;
         pdo_pin_reg <= 1'b1;
         pwm_pin_reg <= 1'b1;
      end
      else
      begin
         cnt_reg     <= cnt_next;
         ff_reg      <= ff_next;
         irq_reg     <= irq_next;
         pdo_pin_reg <= !ff_next;
         pwm_pin_reg <= !ff_next;
      end
   end

   always_ff @(posedge i_clock)
   begin
      if (i_srst)
      begin
         timer_ctrl_reg <= `EBT_CTRL_RST;
         cfg_reg        <= `EBT_CFG_RST;
      end
      else
      begin
         if (ctrl_wr)
            timer_ctrl_reg <= i_wdata;
         if (cfg_wr)
            cfg_reg <= i_wdata[1:0];
      end
   end

   // no shadow: rewriting while running can skip a match
   always_ff @(posedge i_clock)
   begin
      if (i_srst)
         compare_reg <= `EBT_CMP_RST;
      else if (cmp_wr)
         compare_reg <= i_wdata;
   end

   // a write racing the transfer: the old buffer value moves, the new one waits
   always_ff @(posedge i_clock)
   begin
      if (i_srst)
      begin
         duty_buf_reg <= `EBT_DUTY_RST;
         pwm_duty_reg <= `EBT_DUTY_RST;
      end
      else
      begin
         if (duty_wr)
            duty_buf_reg <= i_wdata;
         if (duty_wr && !run)
            pwm_duty_reg <= i_wdata;
         else if (load_duty)
            pwm_duty_reg <= duty_buf_reg;
      end
   end

   always_ff @(posedge i_clock)
   begin
      if (i_srst)
         rdata_reg <= 8'h00;
      else if (i_rd)
      begin
         case (i_addr)
            `EBT_ADDR_CTRL: rdata_reg <= timer_ctrl_reg;
            `EBT_ADDR_CMP:  rdata_reg <= compare_reg;
            `EBT_ADDR_DUTY: rdata_reg <= pwm_duty_reg;
            `EBT_ADDR_CFG:  rdata_reg <= {6'h00, cfg_reg};
            `EBT_ADDR_CNT:  rdata_reg <= cnt_reg;
            default:        rdata_reg <= 8'h00;
         endcase
      end
      else
         rdata_reg <= 8'h00;
   end

   assign o_rdata           = rdata_reg;
   assign o_match_irq       = irq_reg;
   assign o_divider_out_pin = pdo_pin_reg;
   assign o_pwm_out_pin     = pwm_pin_reg;

   default clocking cb @(posedge i_clock);
   endclocking
   default disable iff (i_srst);

   property p_timer_match;
      tick && (mode == ebt_pkg::EBT_MODE_TIMER) && !ctrl_wr
      && (cnt_inc == compare_reg)
      |=> o_match_irq && (cnt_reg == 8'h00);
   endproperty
   a_timer_match: assert property (p_timer_match)
      else $error("timer match lost");

   property p_event_count;
      run && (src == ebt_pkg::EBT_SRC_PIN) && !ev_fall && !ctrl_wr
      |=> $stable(cnt_reg) && !o_match_irq;
   endproperty
   a_event_count: assert property (p_event_count)
      else $error("event counter moved without edge");

   property p_cmp_now;
      cmp_wr ##1 (tick && !ctrl_wr && (mode == ebt_pkg::EBT_MODE_PDO)
      && (cnt_inc == compare_reg))
      |=> o_match_irq && (o_divider_out_pin != $past(o_divider_out_pin));
   endproperty
   a_cmp_now: assert property (p_cmp_now)
      else $error("new compare value not in effect");

   property p_pdo_toggle;
      o_match_irq && (mode == ebt_pkg::EBT_MODE_PDO) && !$past(ctrl_wr)
      |-> (ff_reg != $past(ff_reg));
   endproperty
   a_pdo_toggle: assert property (p_pdo_toggle)
      else $error("divider flip-flop did not toggle");

   property p_pin_inv;
      ##1 (o_divider_out_pin == !ff_reg) && (o_pwm_out_pin == !ff_reg);
   endproperty
   a_pin_inv: assert property (p_pin_inv)
      else $error("pin is not inverse of flip-flop");

   // the stop edge may still carry a last tick, so hold is checked after it
   property p_stop_hold;
      ctrl_wr && run && !i_wdata[`EBT_CTRL_RUN_BIT]
      |=> !run ##1 ($past(ctrl_wr) || $stable(o_pwm_out_pin))
      ##1 ($past(ctrl_wr) || $stable(o_pwm_out_pin));
   endproperty
   a_stop_hold: assert property (p_stop_hold)
      else $error("pin moved on stop");

   property p_ff_load;
      ctrl_wr && !run
      |=> (ff_reg == $past(i_wdata[`EBT_CTRL_FF_BIT]))
      && (cnt_reg == 8'h00);
   endproperty
   a_ff_load: assert property (p_ff_load)
      else $error("flip-flop bit not loaded");

   property p_pwm_duty;
      tick && !ctrl_wr && (mode == ebt_pkg::EBT_MODE_PWM)
      && (cnt_reg != `EBT_CNT_TOP) && (cnt_inc == pwm_duty_reg)
      |=> (ff_reg != $past(ff_reg)) && !o_match_irq;
   endproperty
   a_pwm_duty: assert property (p_pwm_duty)
      else $error("pwm duty toggle missing");

   property p_pwm_ovf;
      tick && !ctrl_wr && (mode == ebt_pkg::EBT_MODE_PWM)
      && (cnt_reg == `EBT_CNT_TOP)
      |=> o_match_irq && (cnt_reg == 8'h00)
      && (pwm_duty_reg == $past(duty_buf_reg));
   endproperty
   a_pwm_ovf: assert property (p_pwm_ovf)
      else $error("pwm overflow handling wrong");

   property p_duty_hold;
      duty_wr && run && !load_duty
      |=> (pwm_duty_reg == $past(pwm_duty_reg));
   endproperty
   a_duty_hold: assert property (p_duty_hold)
      else $error("duty changed before irq");

   property p_duty_stopped;
      duty_wr && !run |=> (pwm_duty_reg == $past(i_wdata));
   endproperty
   a_duty_stopped: assert property (p_duty_stopped)
      else $error("stopped duty write not moved");

   property p_slow_gate;
      cfg_reg[`EBT_CFG_SLOW_BIT] && (src == ebt_pkg::EBT_SRC_FC) |-> !tick;
   endproperty
   a_slow_gate: assert property (p_slow_gate)
      else $error("fast tap ticked in slow mode");

   c_pdo_irq: cover property
      (o_match_irq && (mode == ebt_pkg::EBT_MODE_PDO));
   c_pwm_irq: cover property
      (o_match_irq && (mode == ebt_pkg::EBT_MODE_PWM));
   c_event_irq: cover property
      (o_match_irq && (src == ebt_pkg::EBT_SRC_PIN));
   c_duty_move: cover property
      (duty_wr && run ##[1:600] load_duty);

endmodule

// ===== tb/ebt_far_end.sv
// event pulse source and free low clock at the timer's input pins
`timescale 1ns/10ps
module ebt_far_end
#(
   parameter int LF_HALF = 10
)
(
   input  wire logic       i_clock,
   input  wire logic       i_load,
   input  wire logic [7:0] i_pulses,
   output logic            o_event_in_pin,
   output logic            o_low_freq_clock
);
   logic [7:0] left_reg = 8'h00;
   logic [3:0] ph_reg   = 4'h0;
   int         lf_cnt   = 0;

   // phase restarts on load so no level is cut short
   always_ff @(posedge i_clock)
   begin
      ph_reg <= i_load ? 4'h0 : ph_reg + 4'h1;
      if (i_load)
         left_reg <= i_pulses;
      else if (ph_reg == 4'hf && left_reg != 8'h00)
         left_reg <= left_reg - 8'h01;
   end

   // each level lasts eight clocks, above the two-cycle minimum
   assign o_event_in_pin = !(left_reg != 8'h00 && ph_reg[3]);

   always_ff @(posedge i_clock)
      lf_cnt <= (lf_cnt == 2 * LF_HALF - 1) ? 0 : lf_cnt + 1;
   assign o_low_freq_clock = (lf_cnt < LF_HALF);
endmodule

// ===== tb/ebt_timer_tb_top.sv
// self-checking bench for the 8-bit timer channel
`timescale 1ns/10ps
`include "ebt_cfg.svh"
module ebt_timer_tb_top;
   logic       clk, srst, wr, rd, ld, evp, lfc, rd_q, irq, pdo, pwm;
   logic [2:0] addr;
   logic [7:0] wdata, rdata, pulses;
   logic [7:0] exp_q[$];
   int         miscompares, n_checks, n, low, cmp, d, d2;
   // cfg, source and tick length in clocks (low clock period is 20)
   int         tab[6][3] = '{'{0,0,2048},'{0,1,128},'{0,2,32},'{0,3,8},'{1,0,160},'{2,0,160}};

   ebt_timer i_dut
   (
      .i_clock(clk), .i_srst(srst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
      .i_low_freq_clock(lfc), .i_event_in_pin(evp), .o_rdata(rdata), .o_match_irq(irq),
      .o_divider_out_pin(pdo), .o_pwm_out_pin(pwm)
   );
   ebt_far_end i_far
   (
      .i_clock(clk), .i_load(ld), .i_pulses(pulses), .o_event_in_pin(evp),
      .o_low_freq_clock(lfc)
   );

   always #5 clk = ~clk;

   task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e)
      begin
         miscompares++;
         $display("wrong value %s expected %0h seen %0h", what, e, g);
      end
   endtask

   task automatic test_done;
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // leading edge wait keeps a strobe from being set twice in one step
   task automatic wr_reg(input logic [2:0] a, input logic [7:0] v);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= v;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   task automatic rd_reg(input logic [2:0] a, input logic [7:0] e);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      exp_q.push_back(e);
      @(posedge clk);
      rd <= 1'b0;
   endtask

   always @(posedge clk)
      rd_q <= rd;
   // read data stands only in the cycle after the strobe
   always @(negedge clk)
      if (rd_q === 1'b1)
         chk("rdata", exp_q.pop_front(), rdata);

   task automatic wait_irq(input int lim, output int cyc, output int lo);
      cyc = 0;
      lo = 0;
      do
      begin
         @(posedge clk);
         cyc++;
         if (pwm === 1'b0)
            lo++;
      end while (irq !== 1'b1 && cyc < lim);
      if (irq !== 1'b1)
      begin
         miscompares++;
         test_done();
      end
   endtask

   task automatic pulse(input logic [7:0] v);
      @(posedge clk);
      ld <= 1'b1;
      pulses <= v;
      @(posedge clk);
      ld <= 1'b0;
   endtask

   initial
   begin
      clk = 0; srst = 1; wr = 0; rd = 0; addr = 0; wdata = 0;
      ld = 0; pulses = 0; rd_q = 0; miscompares = 0; n_checks = 0;
      void'($urandom(32'h91618ba5));
      repeat (12) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      chk("pdo reset", 1'b1, pdo);
      chk("pwm reset", 1'b1, pwm);
      for (int a = 0; a < 8; a++)
         rd_reg(a[2:0], 8'h00);
      wr_reg(3'h7, 8'h5a);
      wr_reg(`EBT_ADDR_CNT, 8'h5a);
      rd_reg(3'h7, 8'h00);
      rd_reg(`EBT_ADDR_CNT, 8'h00);

      for (int i = 0; i < 6; i++)
      begin
         cmp = 1 + $urandom % 3;
         wr_reg(`EBT_ADDR_CFG, 8'(tab[i][0]));
         wr_reg(`EBT_ADDR_CMP, 8'(cmp));
         wr_reg(`EBT_ADDR_CTRL, 8'((tab[i][1] << 4) | 8));
         wait_irq(9000, n, low);
         wait_irq(9000, n, low);
         chk("timer period", cmp * tab[i][2], n);
         wr_reg(`EBT_ADDR_CTRL, 8'h00);
      end

      wr_reg(`EBT_ADDR_CFG, 8'h00);
      cmp = 1 + $urandom % 8;
      wr_reg(`EBT_ADDR_CMP, 8'(cmp));
      wr_reg(`EBT_ADDR_CTRL, 8'hb1);
      repeat (2) @(posedge clk);
      chk("pdo init", 1'b0, pdo);
      wr_reg(`EBT_ADDR_CTRL, 8'hb9);
      for (int k = 0; k < 3; k++)
      begin
         wait_irq(2000, n, low);
         // the pin is sampled three clocks in, so that much is missing
         if (k > 0)
            chk("half period", cmp * 8 - 3, n);
         repeat (3) @(posedge clk);
         chk("pdo toggle", !k[0], pdo);
      end
      wr_reg(`EBT_ADDR_CTRL, 8'h00);

      wr_reg(`EBT_ADDR_CMP, 8'h03);
      wr_reg(`EBT_ADDR_CTRL, 8'h78);
      pulse(8'h02);
      repeat (45) @(posedge clk);
      rd_reg(`EBT_ADDR_CNT, 8'h02);
      pulse(8'h01);
      wait_irq(40, n, low);
      rd_reg(`EBT_ADDR_CNT, 8'h00);
      wr_reg(`EBT_ADDR_CTRL, 8'h00);

      d = 2 + $urandom % 253;
      // high phase after overflow must outlast the bus turnaround before the last measurement
      d2 = 3 + $urandom % 248;
      wr_reg(`EBT_ADDR_CTRL, 8'h62);
      wr_reg(`EBT_ADDR_DUTY, 8'(d));
      rd_reg(`EBT_ADDR_DUTY, 8'(d));
      wr_reg(`EBT_ADDR_CTRL, 8'h6a);
      wait_irq(600, n, low);
      wait_irq(600, n, low);
      chk("pwm period", 256, n);
      chk("pwm low", 256 - d, low);
      wr_reg(`EBT_ADDR_DUTY, 8'(d2));
      rd_reg(`EBT_ADDR_DUTY, 8'(d));
      wait_irq(600, n, low);
      rd_reg(`EBT_ADDR_DUTY, 8'(d2));
      wait_irq(600, n, low);
      chk("pwm low new", 256 - d2, low);

      for (n = 0; n < 300 && pwm !== 1'b0; n++)
         @(posedge clk);
      if (pwm !== 1'b0)
         miscompares++;
      wr_reg(`EBT_ADDR_CTRL, 8'h62);
      repeat (20) @(posedge clk);
      chk("pin held", 1'b0, pwm);
      wr_reg(`EBT_ADDR_CTRL, 8'h02);
      repeat (2) @(posedge clk);
      chk("pin released", 1'b1, pwm);
      test_done();
   end
endmodule
